// *** design/master_reset_and_pin_strap_latch.v ***
// Purpose: master reset handling and strap latching for a converter front
//   end, with shared pin function routing per interface mode
// Assumes: all pins synchronous to clk_in; external clock configured
//   when external_clock_enable_in is high
// Notes: outputs are all flip-flops, so pin routing lags one cycle
// How it works
// - in serial mode a low reset pin holds every output register except bias in reset
// - all software-visible registers are forced to defaults during reset
// - serial interface ignores host and stays silent while reset low
// - internal clock gated off during reset, only input stage toggles
// - reset pin and power-on reset drive one shared internal reset
// - biasing stays on in reset; operational right after release
// - in two-wire mode the reset pin is the low oversample select bit
// - low oversample select bit is latched on entry to two-wire mode
// - low oversample select bit is relatched on every watchdog reset in two-wire mode
// - chip select pin is chip select or bias boost select per mode
// - ready pin is ready output or high gain select bit per mode
// - serial clock pin is serial clock or master clock; data in or osr high
// - mode pin low selects serial, high two-wire, latched after resets
// - gain select pins latched on two-wire entry and every watchdog reset in two-wire mode
`timescale 1ns/1ps
`default_nettype none
`include "master_reset_defs.vh"
module master_reset_and_pin_strap_latch (
  input wire clk_in,
  input wire resetn_in,
  input wire external_clock_enable_in,
  input wire mode_pin_in,
  input wire reset_osr_low_pin_in,
  input wire cs_boost_pin_in,
  input wire sck_mclk_pin_in,
  input wire sdi_osr_high_pin_in,
  input wire gain_low_pin_in,
  input wire conversion_done_strobe_in,
  input wire watchdog_reset_in,
  output reg internal_resetn_out,
  output reg clock_gate_enable_out,
  output reg bias_enable_out,
  output reg serial_enable_out,
  output reg serial_cs_n_out,
  output reg serial_clock_out,
  output reg serial_data_out,
  output reg master_clock_sel_out,
  output reg two_wire_mode_out,
  output reg [1:0] oversample_select_out,
  output reg [1:0] amp_select_out,
  output reg boost_select_out,
  output reg ready_pin_drive_out,
  output reg ready_pin_oe_out
);
  // ==========================================================
  // mode latch
  reg mode;
  reg mode_latched;
  reg [1:0] osr_strap;
  reg [1:0] gain_strap;
  wire master_resetn;
  wire sync_resetn;
  wire pin_reset_active;
  wire mode_pin_two_wire;
  wire enter_two_wire;
  wire relatch;

  // ==========================================================
  // mode decode
  // one decode for the mode pin, shared by start-up and watchdog paths
  function pick_mode;
    input two_wire_pin;
    begin
      pick_mode = two_wire_pin ? `MODE_TWO_WIRE : `MODE_SERIAL;
    end
  endfunction

  // reset pin is a reset only while the mode register holds serial
  assign pin_reset_active = (mode == `MODE_SERIAL) && !reset_osr_low_pin_in;
  // power-on and master reset share one source
  assign master_resetn = resetn_in && !pin_reset_active;

  // ==========================================================
  // reset release
  // release aligned to clk so every output register on sync_resetn leaves on one edge
  reset_release_sync #(
    .STAGES(`RST_SYNC_STAGES)
  ) u_sync (
    .clk_in(clk_in),
    .async_resetn_in(master_resetn),
    .sync_resetn_out(sync_resetn)
  );

  assign mode_pin_two_wire = external_clock_enable_in &&
                             (mode_pin_in == `MODE_TWO_WIRE);
  assign enter_two_wire = (mode == `MODE_SERIAL) && mode_pin_two_wire &&
                          mode_latched;
  assign relatch = enter_two_wire ||
                   ((mode == `MODE_TWO_WIRE) && watchdog_reset_in);

  // mode sampled once after any reset release and on watchdog reset;
  // watchdog only counts in two-wire mode. mode register uses power-on
  // reset alone so the pin-reset gate cannot cut its own feedback.
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode <= `MODE_RESET;
      mode_latched <= 1'b0;
    end else if (!sync_resetn) begin
      mode_latched <= 1'b0;
    end else if (!mode_latched) begin
      mode <= pick_mode(mode_pin_two_wire);
      mode_latched <= 1'b1;
    end else if (watchdog_reset_in && (mode == `MODE_TWO_WIRE)) begin
      mode <= pick_mode(mode_pin_two_wire);
    end
  end

  // ==========================================================
  // strap latches
  // captured each cycle the mode is unlatched with the mode pin high, on two-wire watchdog reset, and each cycle serial mode sees the mode pin high; hold otherwise
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osr_strap <= `OSR_SEL_RESET;
      gain_strap <= `GAIN_SEL_RESET;
    end else if (relatch || (!mode_latched && mode_pin_two_wire)) begin
      osr_strap[0] <= reset_osr_low_pin_in;
      osr_strap[1] <= sdi_osr_high_pin_in;
      gain_strap <= {conversion_done_strobe_in, gain_low_pin_in};
    end
  end

  // ==========================================================
  // output registers
  // all visible state except bias_enable_out reset via the shared synchronous-release reset
  always @(posedge clk_in or negedge sync_resetn) begin
    if (!sync_resetn) begin
      internal_resetn_out <= 1'b0;
      clock_gate_enable_out <= 1'b0;
      serial_enable_out <= 1'b0;
      serial_cs_n_out <= 1'b1;
      serial_clock_out <= 1'b0;
      serial_data_out <= 1'b0;
      master_clock_sel_out <= 1'b0;
      two_wire_mode_out <= `MODE_RESET;
      oversample_select_out <= `OSR_SEL_RESET;
      amp_select_out <= `GAIN_SEL_RESET;
      boost_select_out <= `BOOST_SEL_RESET;
      ready_pin_drive_out <= 1'b1;
      ready_pin_oe_out <= 1'b0;
    end else begin
      internal_resetn_out <= 1'b1;
      clock_gate_enable_out <= 1'b1;
      two_wire_mode_out <= mode;
      if (mode == `MODE_SERIAL) begin
        serial_enable_out <= 1'b1;
        serial_cs_n_out <= cs_boost_pin_in;
        serial_clock_out <= sck_mclk_pin_in;
        serial_data_out <= sdi_osr_high_pin_in;
        master_clock_sel_out <= 1'b0;
        boost_select_out <= `BOOST_SEL_RESET;
        oversample_select_out <= `OSR_SEL_RESET;
        amp_select_out <= `GAIN_SEL_RESET;
        ready_pin_drive_out <= conversion_done_strobe_in;
        ready_pin_oe_out <= 1'b1;
      end else begin
        serial_enable_out <= 1'b0;
        serial_cs_n_out <= 1'b1;
        serial_clock_out <= 1'b0;
        serial_data_out <= 1'b0;
        master_clock_sel_out <= 1'b1;
        boost_select_out <= cs_boost_pin_in;
        oversample_select_out <= osr_strap;
        amp_select_out <= gain_strap;
        ready_pin_drive_out <= 1'b1;
        ready_pin_oe_out <= 1'b0;
      end
    end
  end

  // bias is analog-facing and never cut by master reset
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bias_enable_out <= 1'b1;
    end else begin
      bias_enable_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** design/master_reset_defs.vh ***
// Purpose: constants for the master reset and pin strap latch block
// Assumes: included by bare name from design files
// Notes: mode and strap encodings, reset values, sync depth
`ifndef MASTER_RESET_DEFS_VH
`define MASTER_RESET_DEFS_VH
// ==========================================================
// interface mode encodings
`define MODE_SERIAL 1'h0
`define MODE_TWO_WIRE 1'h1
// ==========================================================
// reset values of latched straps and control state
`define OSR_SEL_RESET 2'h0
`define GAIN_SEL_RESET 2'h0
`define BOOST_SEL_RESET 1'h0
`define MODE_RESET 1'h0
// ==========================================================
// reset release synchroniser depth
`define RST_SYNC_STAGES 2
`endif

// *** design/reset_release_sync.v ***
// Purpose: asynchronous assert, synchronous release of internal reset
// Assumes: clk_in runs while release is wanted
// Notes: depth set by a parameter, minimum two stages
`timescale 1ns/1ps
`default_nettype none
`include "master_reset_defs.vh"
module reset_release_sync #(
  parameter STAGES = `RST_SYNC_STAGES
) (
  input wire clk_in,
  input wire async_resetn_in,
  output wire sync_resetn_out
);
  // ==========================================================
  // shift chain
  reg [STAGES-1:0] chain;
  // ones shift in after release; all stages clear at once on assert
  always @(posedge clk_in or negedge async_resetn_in) begin
    if (!async_resetn_in) begin
      chain <= {STAGES{1'b0}};
    end else begin
      chain <= {chain[STAGES-2:0], 1'b1};
    end
  end
  assign sync_resetn_out = chain[STAGES-1];
endmodule
`default_nettype wire

// *** testbench/master_reset_checker_assertions.sv ***
// Purpose: port-level checks on reset handling and strap latching
// Assumes: bound to the top module, one clock domain
// Notes: pin paths are judged one cycle late, straps two
`timescale 1ns/1ps
`default_nettype none
module master_reset_checker (
  input wire logic clk_in, resetn_in, external_clock_enable_in, mode_pin_in,
  input wire logic reset_osr_low_pin_in, cs_boost_pin_in, sck_mclk_pin_in,
  input wire logic sdi_osr_high_pin_in, gain_low_pin_in, watchdog_reset_in,
  input wire logic conversion_done_strobe_in, internal_resetn_out,
  input wire logic clock_gate_enable_out, bias_enable_out, serial_enable_out,
  input wire logic serial_cs_n_out, serial_clock_out, serial_data_out,
  input wire logic two_wire_mode_out, ready_pin_drive_out, ready_pin_oe_out,
  input wire logic [1:0] oversample_select_out, amp_select_out
);
  // ==========================================================
  // checks in the master clock domain
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // watchdog in two-wire, pins held across the capture edge
  sequence s_wd;
    two_wire_mode_out && watchdog_reset_in && external_clock_enable_in
    ##1 $stable({mode_pin_in, reset_osr_low_pin_in, sdi_osr_high_pin_in,
      gain_low_pin_in, conversion_done_strobe_in}) && mode_pin_in;
  endsequence
  a_bias_stays_on: assert property (bias_enable_out)
    else $error("bias dropped");
  a_pin_holds_reset: assert property
    ((!two_wire_mode_out && !reset_osr_low_pin_in)[*3] |-> !internal_resetn_out)
    else $error("pin reset not taken");
  a_reset_is_silent: assert property (!internal_resetn_out[*2] |->
    serial_cs_n_out && !serial_enable_out && !serial_clock_out)
    else $error("serial active in reset");
  a_clock_gated_off: assert property
    (!internal_resetn_out[*2] |-> !clock_gate_enable_out)
    else $error("clock runs in reset");
  a_two_wire_no_reset: assert property
    (two_wire_mode_out[*2] |-> internal_resetn_out)
    else $error("reset in two-wire");
  a_cs_forwarded: assert property (serial_enable_out[*2] |->
    serial_cs_n_out == $past(cs_boost_pin_in) &&
    serial_data_out == $past(sdi_osr_high_pin_in))
    else $error("serial pins not forwarded");
  a_ready_forwarded: assert property (ready_pin_oe_out[*2] |->
    ready_pin_drive_out == $past(conversion_done_strobe_in))
    else $error("ready not forwarded");
  a_watchdog_straps: assert property (s_wd |=>
    oversample_select_out == $past({sdi_osr_high_pin_in, reset_osr_low_pin_in})
    && amp_select_out == $past({conversion_done_strobe_in, gain_low_pin_in}))
    else $error("straps not recaptured");
endmodule
bind master_reset_and_pin_strap_latch master_reset_checker chk (.*);
`default_nettype wire

// *** testbench/host_pin_model.sv ***
// Purpose: host side driving the shared strap and control pins
// Assumes: vector order mode, reset, cs, sck, sdi, gain, ready
// Notes: pins move only just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
  input wire logic clk_in,
  output var logic mode_pin_out, rst_pin_out, cs_pin_out, sck_pin_out,
  output var logic sdi_pin_out, gain_pin_out, ready_pin_out
);
  // set every pin at once so straps never straddle an edge
  task automatic put(input logic [6:0] v);
    @(posedge clk_in) {mode_pin_out, rst_pin_out, cs_pin_out, sck_pin_out,
      sdi_pin_out, gain_pin_out, ready_pin_out} <= v;
  endtask
  initial {mode_pin_out, rst_pin_out, cs_pin_out, sck_pin_out,
    sdi_pin_out, gain_pin_out, ready_pin_out} = 7'h30;
endmodule
`default_nettype wire

// *** testbench/master_reset_and_pin_strap_latch_test.sv ***
// Purpose: self-checking bench for master reset and strap latching
// Assumes: external clock stays configured so the mode pin counts
// Notes: outputs sampled 1 ns after the edge to dodge races
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module master_reset_and_pin_strap_latch_test;
  logic clk_in, resetn_in, external_clock_enable_in, mode_pin_in;
  logic reset_osr_low_pin_in, cs_boost_pin_in, sck_mclk_pin_in;
  logic sdi_osr_high_pin_in, gain_low_pin_in, conversion_done_strobe_in;
  logic watchdog_reset_in, internal_resetn_out, clock_gate_enable_out;
  logic bias_enable_out, serial_enable_out, serial_cs_n_out, serial_clock_out;
  logic serial_data_out, master_clock_sel_out, two_wire_mode_out;
  logic boost_select_out, ready_pin_drive_out, ready_pin_oe_out;
  logic [1:0] oversample_select_out, amp_select_out;
  int err_total = 0;
  int compares = 0;
  master_reset_and_pin_strap_latch dut (.*);
  host_pin_model host (.clk_in(clk_in), .mode_pin_out(mode_pin_in),
    .rst_pin_out(reset_osr_low_pin_in), .cs_pin_out(cs_boost_pin_in),
    .sck_pin_out(sck_mclk_pin_in), .sdi_pin_out(sdi_osr_high_pin_in),
    .gain_pin_out(gain_low_pin_in), .ready_pin_out(conversion_done_strobe_in));
  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic por(input logic [6:0] pins);
    host.put(pins);
    @(posedge clk_in) resetn_in <= 1'h0;
    step(6);
    @(posedge clk_in) resetn_in <= 1'h1;
    step(6);
  endtask
  // ==========================================================
  // serial mode: forwarding, then the reset pin holds the chip
  task automatic serial_test();
    por(7'h30);
    `CHK("rst", 1'h1, internal_resetn_out)
    host.put(7'h2c);
    step(2);
    `CHK("cs", 1'h0, serial_cs_n_out)
    `CHK("sck", 1'h1, serial_clock_out)
    `CHK("rdy", 1'h0, ready_pin_drive_out)
    `CHK("rdyoe", 1'h1, ready_pin_oe_out)
    `CHK("sdi", 1'h1, serial_data_out)
    `CHK("mclk", 1'h0, master_clock_sel_out)
    `CHK("osr", 2'h0, oversample_select_out)
    host.put(7'h0c);
    step(4);
    `CHK("rst", 1'h0, internal_resetn_out)
    `CHK("gate", 1'h0, clock_gate_enable_out)
    `CHK("cs", 1'h1, serial_cs_n_out)
    `CHK("ser", 1'h0, serial_enable_out)
    `CHK("bias", 1'h1, bias_enable_out)
    host.put(7'h2c);
    step(5);
    `CHK("rst", 1'h1, internal_resetn_out)
    $display("serial test done");
  endtask
  // two-wire: straps on entry, pin is no reset, watchdog recapture
  task automatic two_wire_test();
    por(7'h72);
    `CHK("mode", 1'h1, two_wire_mode_out)
    `CHK("osr", 2'h1, oversample_select_out)
    `CHK("amp", 2'h1, amp_select_out)
    `CHK("boost", 1'h1, boost_select_out)
    `CHK("mclk", 1'h1, master_clock_sel_out)
    `CHK("ser", 1'h0, serial_enable_out)
    `CHK("rdyoe", 1'h0, ready_pin_oe_out)
    host.put(7'h45);
    step(4);
    `CHK("rst", 1'h1, internal_resetn_out)
    @(posedge clk_in) watchdog_reset_in <= 1'h1;
    @(posedge clk_in) watchdog_reset_in <= 1'h0;
    step(3);
    `CHK("osr", 2'h2, oversample_select_out)
    `CHK("amp", 2'h2, amp_select_out)
    `CHK("boost", 1'h0, boost_select_out)
    $display("two-wire test done");
  endtask
  task automatic conclude();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // clock, hang guard and main sequence
  initial begin
    clk_in = 1'h0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    err_total++;
    conclude();
  end
  initial begin
    resetn_in = 1'h0;
    external_clock_enable_in = 1'h1;
    watchdog_reset_in = 1'h0;
    serial_test();
    two_wire_test();
    conclude();
  end
endmodule
`default_nettype wire
